//--- rofb_map.svh
// Constants of the output frame builder: layout, codes and timing counts.
// Assumes it is included by the design modules that need the numbers.
`ifndef ROFB_MAP_SVH
`define ROFB_MAP_SVH

// Frame layout; offsets are byte positions inside a 508-byte segment.
`define ROFB_FRAME_BYTES 5082
`define ROFB_SEG_BYTES   508
`define ROFB_TENTHS      10
`define ROFB_FRAME_ID    8'hB7
`define ROFB_ID_OFF      9'h000
`define ROFB_STAT_OFF    9'h003
`define ROFB_SPEC_FIRST  9'h006
`define ROFB_SPEC_LAST   9'h01B
`define ROFB_SPEC_STEP   9'h003
`define ROFB_PWR_BYTES   3'h5
`define ROFB_PWR_W       40
`define ROFB_TAG_W       24

// Time base; the tenth-frame time is kept in microseconds.
`define ROFB_CLK_HZ      25000000
`define ROFB_SMP_HZ      10000000
`define ROFB_TENTH_US    102400
`define ROFB_PAIRS_TENTH 125
`define ROFB_TENTH_SMP   (`ROFB_TENTH_US * (`ROFB_SMP_HZ / 1000000))
`define ROFB_DECIM       (`ROFB_TENTH_SMP / `ROFB_PAIRS_TENTH)

// Test patterns; square waves toggle on a bit of the sample count.
`define ROFB_IMP_VAL     16'h0080
`define ROFB_IMP_LEN     2'h2
`define ROFB_SQ_POS      16'h0100
`define ROFB_SQ_NEG      16'hFF00
`define ROFB_SQ_LO_BIT   13
`define ROFB_SQ_MID_BIT  8
`define ROFB_SQ_HI_BIT   6
`define ROFB_LFSR_SEED   16'hACE1

`endif

//--- rofb_pkg.sv
// Types shared by the output frame builder and its pattern source.
// Assumes nothing of its surroundings.
package rofb_pkg;

  typedef enum logic [1:0] {
    ROFB_ST_IDLE = 2'h0,
    ROFB_ST_RUN  = 2'h1
  } rofb_state_t;

  typedef enum logic [2:0] {
    ROFB_SEL_ADC    = 3'h0,
    ROFB_SEL_IMP    = 3'h1,
    ROFB_SEL_SQ_LO  = 3'h2,
    ROFB_SEL_SQ_MID = 3'h3,
    ROFB_SEL_PRN1   = 3'h4,
    ROFB_SEL_PRNF   = 3'h5,
    ROFB_SEL_SQ_HI  = 3'h6,
    ROFB_SEL_ZERO   = 3'h7
  } rofb_sel_t;

  typedef enum logic [1:0] {
    ROFB_K_ID   = 2'h0,
    ROFB_K_STAT = 2'h1,
    ROFB_K_SPEC = 2'h2,
    ROFB_K_IQ   = 2'h3
  } rofb_kind_t;

  typedef logic signed [15:0] rofb_smp_t;

endpackage : rofb_pkg

//--- rofb_smp_if.sv
// Sample path between the frame builder and the test-pattern source.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface rofb_smp_if;
  import rofb_pkg::*;

  logic      smp_stb;
  logic      frm_evt;
  rofb_sel_t sel;
  rofb_smp_t adc;
  rofb_smp_t smp;

  modport gen (input smp_stb, input frm_evt, input sel, input adc,
               output smp);
  modport usr (output smp_stb, output frm_evt, output sel, output adc,
               input smp);

endinterface : rofb_smp_if

//--- rofb_pattern.sv
// Input selector: converter samples or one of seven test patterns.
// Assumes one sample strobe per 10 Msample/s sample and a frame event.
`timescale 1ns/1ps
`include "rofb_map.svh"
module rofb_pattern
  import rofb_pkg::*;
(
  input  wire logic sys_clk_i, // System clock.
  input  wire logic rst_i,     // Asynchronous reset, active high.
  rofb_smp_if.gen   smp_if     // Strobes and select in, sample out.
);

  logic [13:0] cnt_q;
  logic [1:0]  imp_q;
  logic [15:0] lfsr_q;
  logic        fb;

  assign fb = lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10];

  // Pattern phase restarts each frame so every frame is identical.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_q <= '0;
    else if (smp_if.frm_evt)
      cnt_q <= '0;
    else if (smp_if.smp_stb)
      cnt_q <= cnt_q + 14'h0001;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      imp_q <= '0;
    else if (smp_if.frm_evt)
      imp_q <= '0;
    else if (smp_if.smp_stb && imp_q != `ROFB_IMP_LEN)
      imp_q <= imp_q + 2'h1;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      lfsr_q <= `ROFB_LFSR_SEED;
    else if (smp_if.frm_evt)
      lfsr_q <= `ROFB_LFSR_SEED;
    else if (smp_if.smp_stb)
      lfsr_q <= {lfsr_q[14:0], fb};
  end

  always_comb
  begin
    unique case (smp_if.sel)
      ROFB_SEL_ADC:    smp_if.smp = smp_if.adc;
      ROFB_SEL_IMP:    smp_if.smp = (imp_q != `ROFB_IMP_LEN) ?
                                    `ROFB_IMP_VAL : 16'h0000;
      ROFB_SEL_SQ_LO:  smp_if.smp = cnt_q[`ROFB_SQ_LO_BIT] ?
                                    `ROFB_SQ_NEG : `ROFB_SQ_POS;
      ROFB_SEL_SQ_MID: smp_if.smp = cnt_q[`ROFB_SQ_MID_BIT] ?
                                    `ROFB_SQ_NEG : `ROFB_SQ_POS;
      ROFB_SEL_SQ_HI:  smp_if.smp = cnt_q[`ROFB_SQ_HI_BIT] ?
                                    `ROFB_SQ_NEG : `ROFB_SQ_POS;
      ROFB_SEL_PRN1:   smp_if.smp = lfsr_q[0] ? 16'hFFFF : 16'h0001;
      ROFB_SEL_PRNF:   smp_if.smp = lfsr_q;
      ROFB_SEL_ZERO:   smp_if.smp = 16'h0000;
    endcase
  end

endmodule : rofb_pattern

//--- rofb_frame_builder.sv
// Output frame builder: samples, power, time tags and I/Q into frames.
// Assumes a reference clock on sys_clk_i and a consumer on this clock.
//
// How it works
// - Each frame is exactly 5082 bytes.
// - Frame byte 0 is always B7.
// - Status byte carries select in bits 6..4.
// - Nonzero select feeds a test pattern instead.
// - Select 000 passes converter samples, status zero.
// - Select 001 gives two 128 samples per frame.
// - Select 010 gives +/-256 square at 610 Hz.
// - Select 011 gives +/-256 square at 19.5 kHz.
// - Select 110 gives +/-256 square at 78 kHz.
// - Select 100 gives random +/-1 samples.
// - Select 101 full-scale random, 111 all zero.
// - Power sums every sample squared.
// - Power sum clears each frame; ten snapshots.
// - Power is 40 bits, five bytes, MSB first.
// - Power snapshots one tenth frame apart.
// - First power slot holds frame-start snapshot.
// - First tag after start is zero, then increments.
// - Tag counter never clears at frame boundaries.
// - Tag advances once per tenth frame.
// - Tag is 24 bits, three bytes, MSB first.
// - 1250 I/Q pairs of signed 16 bits.
// - Mix 2.5 MHz carrier to zero, then filter.
// - Frames start at next strobe, then continuous.
// - All logic runs from the reference oscillator clock.
// - Power bytes at offset 6 step 3, segments 508.
// - I then Q fill all remaining bytes.
`timescale 1ns/1ps
`include "rofb_map.svh"
module rofb_frame_builder
  import rofb_pkg::*;
#(
  parameter int ADC_W = 12,
  parameter int DECIM = `ROFB_DECIM
)
(
  input  wire logic             sys_clk_i,   // Reference clock.
  input  wire logic             rst_i,       // Asynchronous reset.
  input  wire logic             pps_i,       // Once-per-second strobe.
  input  wire logic [2:0]       input_sel_i, // Input-select setting.
  input  wire logic [ADC_W-1:0] adc_data_i,  // Converter sample, signed.
  input  wire logic             out_ready_i, // Consumer takes a byte.
  output logic                  out_valid_o, // Byte is valid.
  output logic [7:0]            out_data_o,  // Output frame byte.
  output logic                  out_sof_o,   // Byte is frame byte 0.
  output logic                  running_o    // Frames are being built.
);

  localparam int DL = $clog2(DECIM);
  localparam int SW = 17 + DL;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic             pps_m_q;
  logic             pps_s_q;
  logic             pps_d_q;
  logic [2:0]       sel_m_q;
  logic [2:0]       sel_s_q;
  logic [ADC_W-1:0] adc_m_q;
  logic [ADC_W-1:0] adc_s_q;
  logic             pps_rise;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pps_m_q <= 1'b0;
      pps_s_q <= 1'b0;
      pps_d_q <= 1'b0;
      sel_m_q <= '0;
      sel_s_q <= '0;
      adc_m_q <= '0;
      adc_s_q <= '0;
    end
    else
    begin
      pps_m_q <= pps_i;
      pps_s_q <= pps_m_q;
      pps_d_q <= pps_s_q;
      sel_m_q <= input_sel_i;
      sel_s_q <= sel_m_q;
      adc_m_q <= adc_data_i;
      adc_s_q <= adc_m_q;
    end
  end

  assign pps_rise = pps_s_q & ~pps_d_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sample strobe: 10 Msample/s drawn from the reference clock.

  logic [25:0] ph_q;
  logic [25:0] ph_nx;
  logic        smp_stb;

  assign ph_nx   = ph_q + 26'(`ROFB_SMP_HZ);
  assign smp_stb = ph_nx >= 26'(`ROFB_CLK_HZ);

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ph_q <= '0;
    else if (smp_stb)
      ph_q <= ph_nx - 26'(`ROFB_CLK_HZ);
    else
      ph_q <= ph_nx;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run control and frame timing.

  rofb_state_t st_q;
  logic        run;
  logic        start_evt;
  logic [DL-1:0] scnt_q;
  logic [6:0]  pcnt_q;
  logic [3:0]  tcnt_q;
  logic        pair_end;
  logic        tenth_end;
  logic        frame_end;
  logic        tenth_evt;
  logic        frame_evt;

  assign run       = (st_q == ROFB_ST_RUN);
  assign start_evt = (st_q == ROFB_ST_IDLE) & pps_rise;
  assign pair_end  = run & smp_stb & (scnt_q == DL'(DECIM - 1));
  assign tenth_end = pair_end & (pcnt_q == 7'(`ROFB_PAIRS_TENTH - 1));
  assign frame_end = tenth_end & (tcnt_q == 4'(`ROFB_TENTHS - 1));
  assign tenth_evt = start_evt | tenth_end;
  assign frame_evt = start_evt | frame_end;
  assign running_o = run;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      st_q <= ROFB_ST_IDLE;
    else
    begin
      unique case (st_q)
        ROFB_ST_IDLE: if (pps_rise) st_q <= ROFB_ST_RUN;
        ROFB_ST_RUN:  st_q <= ROFB_ST_RUN;
        default:      st_q <= ROFB_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scnt_q <= '0;
      pcnt_q <= '0;
      tcnt_q <= '0;
    end
    else if (start_evt)
    begin
      scnt_q <= '0;
      pcnt_q <= '0;
      tcnt_q <= '0;
    end
    else if (run && smp_stb)
    begin
      scnt_q <= scnt_q + DL'(1);
      if (tenth_end)
        pcnt_q <= '0;
      else if (pair_end)
        pcnt_q <= pcnt_q + 7'h01;
      if (frame_end)
        tcnt_q <= '0;
      else if (tenth_end)
        tcnt_q <= tcnt_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input selection.

  rofb_smp_if smp_if ();
  logic [2:0] stat_q;

  assign smp_if.smp_stb = smp_stb;
  assign smp_if.frm_evt = frame_evt;
  assign smp_if.sel     = rofb_sel_t'(sel_s_q);
  assign smp_if.adc     = 16'($signed(adc_s_q));

  rofb_pattern u_pattern (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .smp_if    (smp_if)
  );

  // The status byte reports the setting in force when the frame began.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      stat_q <= '0;
    else if (frame_evt)
      stat_q <= sel_s_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Integrated power and time tags.

  logic signed [31:0] x32;
  logic [31:0]        pwr_sq;
  logic [39:0]        acc_q;
  logic [39:0]        acc_sum;
  logic [39:0]        pwr_snap_q;
  logic [23:0]        tag_q;
  logic [23:0]        tag_snap_q;

  assign x32     = 32'(smp_if.smp);
  assign pwr_sq  = 32'(x32 * x32);
  assign acc_sum = acc_q + 40'(pwr_sq);

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      acc_q <= '0;
    else if (frame_evt)
      acc_q <= '0;
    else if (run && smp_stb)
      acc_q <= acc_sum;
  end

  // The frame-start snapshot holds the whole previous frame's sum.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pwr_snap_q <= '0;
    else if (start_evt)
      pwr_snap_q <= acc_q;
    else if (tenth_end)
      pwr_snap_q <= acc_sum;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tag_q      <= '0;
      tag_snap_q <= '0;
    end
    else if (tenth_evt)
    begin
      tag_snap_q <= tag_q;
      tag_q      <= tag_q + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Downconversion: quarter-rate mixer and integrate-and-dump filter.

  logic [1:0]         lo_q;
  logic signed [16:0] x17;
  logic signed [16:0] mix_i;
  logic signed [16:0] mix_q;
  logic signed [SW-1:0] si_q;
  logic signed [SW-1:0] sq_q;
  logic signed [SW-1:0] si_nx;
  logic signed [SW-1:0] sq_nx;
  logic [15:0]        pi_q;
  logic [15:0]        pq_q;

  function automatic logic [15:0] rofb_sat(input logic signed [SW-1:0] v);
    logic signed [SW-1:0] a;
    a = v >>> DL;
    if (a > SW'(32767))
      return 16'h7FFF;
    else if (a < -SW'(32768))
      return 16'h8000;
    else
      return a[15:0];
  endfunction : rofb_sat

  assign x17 = 17'(smp_if.smp);

  // The carrier sits at a quarter of the sample rate, so the local
  // oscillator is the exact sequence 1, 0, -1, 0.
  always_comb
  begin
    unique case (lo_q)
      2'h0:    begin mix_i = x17;  mix_q = '0;   end
      2'h1:    begin mix_i = '0;   mix_q = -x17; end
      2'h2:    begin mix_i = -x17; mix_q = '0;   end
      2'h3:    begin mix_i = '0;   mix_q = x17;  end
    endcase
  end

  assign si_nx = si_q + SW'(mix_i);
  assign sq_nx = sq_q + SW'(mix_q);

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      lo_q <= '0;
    else if (frame_evt)
      lo_q <= '0;
    else if (run && smp_stb)
      lo_q <= lo_q + 2'h1;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      si_q <= '0;
      sq_q <= '0;
    end
    else if (start_evt || pair_end)
    begin
      si_q <= '0;
      sq_q <= '0;
    end
    else if (run && smp_stb)
    begin
      si_q <= si_nx;
      sq_q <= sq_nx;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pi_q <= '0;
      pq_q <= '0;
    end
    else if (pair_end)
    begin
      pi_q <= rofb_sat(si_nx);
      pq_q <= rofb_sat(sq_nx);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame byte sequencer.

  logic [3:0]  seg_q;
  logic [8:0]  off_q;
  logic [1:0]  iqb_q;
  logic        pend_q;
  logic [8:0]  sdiff;
  logic [2:0]  sidx;
  logic [2:0]  bidx;
  logic [31:0] iq_word;
  rofb_kind_t  kind;
  logic [7:0]  byte_d;
  logic        avail;
  logic        load;
  logic        iq_done;
  logic        seg_end;
  logic        out_valid_q;
  logic [7:0]  out_data_q;
  logic        out_sof_q;

  assign iq_word = {pi_q, pq_q};

  always_comb
  begin
    sdiff = off_q - `ROFB_SPEC_FIRST;
    sidx  = 3'(sdiff / `ROFB_SPEC_STEP);
    bidx  = '0;
    if (seg_q == 4'h0 && off_q == `ROFB_ID_OFF)
      kind = ROFB_K_ID;
    else if (seg_q == 4'h0 && off_q == `ROFB_STAT_OFF)
      kind = ROFB_K_STAT;
    else if (off_q >= `ROFB_SPEC_FIRST && off_q <= `ROFB_SPEC_LAST &&
             sdiff % `ROFB_SPEC_STEP == 9'h000)
      kind = ROFB_K_SPEC;
    else
      kind = ROFB_K_IQ;
    unique case (kind)
      ROFB_K_ID:   byte_d = `ROFB_FRAME_ID;
      ROFB_K_STAT: byte_d = {1'b0, stat_q, 4'h0};
      ROFB_K_SPEC:
      begin
        if (sidx < `ROFB_PWR_BYTES)
        begin
          bidx   = 3'(3'h4 - sidx);
          byte_d = pwr_snap_q[{bidx, 3'h0} +: 8];
        end
        else
        begin
          bidx   = 3'(3'h7 - sidx);
          byte_d = tag_snap_q[{bidx[1:0], 3'h0} +: 8];
        end
      end
      ROFB_K_IQ:   byte_d = iq_word[{~iqb_q, 3'h0} +: 8];
    endcase
  end

  assign avail   = (kind != ROFB_K_IQ) | pend_q;
  assign load    = run & avail & (~out_valid_q | out_ready_i);
  assign iq_done = load & (kind == ROFB_K_IQ) & (iqb_q == 2'h3);
  assign seg_end = (seg_q == 4'(`ROFB_TENTHS - 1)) ?
    (off_q == 9'(`ROFB_FRAME_BYTES - 9 * `ROFB_SEG_BYTES - 1)) :
    (off_q == 9'(`ROFB_SEG_BYTES - 1));

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      seg_q <= '0;
      off_q <= '0;
    end
    else if (load && seg_end)
    begin
      off_q <= '0;
      seg_q <= (seg_q == 4'(`ROFB_TENTHS - 1)) ? 4'h0 : seg_q + 4'h1;
    end
    else if (load)
      off_q <= off_q + 9'h001;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      iqb_q <= '0;
    else if (load && kind == ROFB_K_IQ)
      iqb_q <= iqb_q + 2'h1;
  end

  // A new pair in the cycle its last byte leaves keeps the flag set.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pend_q <= 1'b0;
    else if (pair_end)
      pend_q <= 1'b1;
    else if (iq_done)
      pend_q <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
      out_sof_q   <= 1'b0;
    end
    else if (load)
    begin
      out_valid_q <= 1'b1;
      out_data_q  <= byte_d;
      out_sof_q   <= (kind == ROFB_K_ID);
    end
    else if (out_ready_i)
      out_valid_q <= 1'b0;
  end

  assign out_valid_o = out_valid_q;
  assign out_data_o  = out_data_q;
  assign out_sof_o   = out_sof_q;

endmodule : rofb_frame_builder

//--- rofb_chk.sv
// Port checker of the output frame builder's byte stream and start-up.
// Assumes it is bound into rofb_frame_builder; one clock domain.
`timescale 1ns/1ps
module rofb_chk
#(
  parameter int DECIM = 8192
)
(
  input wire logic       sys_clk_i,   // Reference clock.
  input wire logic       rst_i,       // Asynchronous reset.
  input wire logic       pps_i,       // Once-per-second strobe.
  input wire logic [2:0] input_sel_i, // Input select.
  input wire logic       out_ready_i, // Consumer ready.
  input wire logic       out_valid_o, // Byte valid.
  input wire logic [7:0] out_data_o,  // Frame byte.
  input wire logic       out_sof_o,   // Frame byte 0.
  input wire logic       running_o    // Frames running.
);
  localparam int PLO = 3125 * DECIM - 8;
  localparam int PHI = 3125 * DECIM + 8;
  logic        take;
  logic        rise;
  logic        fs_q;
  logic        seen_q;
  logic        got_q;
  logic [12:0] idx_q;
  logic [31:0] cyc_q;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  assign take = out_valid_o & out_ready_i;
  assign rise = out_valid_o & out_sof_o & ~fs_q;
  ////////////////////////////////////////
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      idx_q  <= 13'h0000;
      seen_q <= 1'b0;
    end
    else if (take)
    begin
      idx_q  <= out_sof_o ? 13'h0001 : idx_q + 13'h0001;
      seen_q <= seen_q | out_sof_o;
    end
  end
  // Measures the spacing of frame starts offered on the stream.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fs_q  <= 1'b0;
      got_q <= 1'b0;
      cyc_q <= 32'h0;
    end
    else
    begin
      fs_q  <= out_valid_o & out_sof_o;
      got_q <= got_q | rise;
      cyc_q <= rise ? 32'h1 : cyc_q + 32'h1;
    end
  end
  property p_sof_id;
    out_valid_o && out_sof_o |-> out_data_o == 8'hB7;
  endproperty
  a_sof_id: assert property (p_sof_id)
    else $error("frame start byte is not the identifier");
  property p_len;
    take && out_sof_o && seen_q |-> idx_q == 13'h13DA;
  endproperty
  a_len: assert property (p_len)
    else $error("frame length wrong");
  property p_status;
    take && idx_q == 13'h0003 && !out_sof_o
      |-> out_data_o == {1'b0, input_sel_i, 4'h0};
  endproperty
  a_status: assert property (p_status)
    else $error("status byte wrong");
  property p_hold;
    out_valid_o && !out_ready_i
      |=> out_valid_o && $stable(out_data_o) && $stable(out_sof_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("offered byte changed before it was taken");
  property p_idle;
    !running_o |-> !out_valid_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("byte offered before start");
  property p_start;
    !running_o && $rose(pps_i) |-> ##[1:5] running_o;
  endproperty
  a_start: assert property (p_start)
    else $error("strobe did not start framing");
  property p_first;
    $rose(running_o) |-> ##[0:2] (out_valid_o && out_sof_o);
  endproperty
  a_first: assert property (p_first)
    else $error("first frame byte late");
  property p_run;
    running_o |=> running_o;
  endproperty
  a_run: assert property (p_run)
    else $error("framing stopped");
  property p_period;
    rise && got_q |-> cyc_q >= PLO && cyc_q <= PHI;
  endproperty
  a_period: assert property (p_period)
    else $error("frame period wrong");
endmodule : rofb_chk

bind rofb_frame_builder rofb_chk #(.DECIM(DECIM)) u_chk
(
  .sys_clk_i   (sys_clk_i),
  .rst_i       (rst_i),
  .pps_i       (pps_i),
  .input_sel_i (input_sel_i),
  .out_ready_i (out_ready_i),
  .out_valid_o (out_valid_o),
  .out_data_o  (out_data_o),
  .out_sof_o   (out_sof_o),
  .running_o   (running_o)
);

//--- rofb_partner.sv
// Far side model: sample converter and data-handling byte consumer.
// Assumes the builder's clock; slow_i makes the consumer stall.
`timescale 1ns/1ps
module rofb_partner
(
  input  wire logic        sys_clk_i, // Clock.
  input  wire logic        rst_i,     // Reset.
  input  wire logic        slow_i,    // Stall one cycle in four.
  output logic             ready_o,   // Consumer ready.
  output logic [11:0]      adc_o      // Converter sample.
);
  logic [1:0] cnt_q;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_q <= 2'h0;
    else
      cnt_q <= cnt_q + 2'h1;
  end
  // The sample flips sign each clock, so every sample squares the same.
  assign adc_o   = cnt_q[0] ? 12'h040 : 12'hFC0;
  assign ready_o = !slow_i || (cnt_q != 2'h0);
endmodule : rofb_partner

//--- tb_rofb_frame_builder.sv
// Bench of the output frame builder: one whole frame per input select.
// Assumes a 25 MHz clock and a pair period shortened to DEC samples.
`timescale 1ns/1ps
module tb_rofb_frame_builder;
  localparam int DEC = 4;
  localparam int T   = 125 * DEC;
  logic        sys_clk_i;
  logic        rst_i;
  logic        pps_i;
  logic [2:0]  input_sel_i;
  logic [11:0] adc_data_i;
  logic        out_ready_i;
  logic        out_valid_o;
  logic [7:0]  out_data_o;
  logic        out_sof_o;
  logic        running_o;
  logic        slow;
  logic        sof0;
  logic [7:0]  fb [0:5081];
  logic [39:0] pw [0:9];
  int          bad_count;
  int          num_checks;
  int          fr;
  int          cyc;
  rofb_frame_builder #(.ADC_W(12), .DECIM(DEC)) dut
  (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .pps_i       (pps_i),
    .input_sel_i (input_sel_i),
    .adc_data_i  (adc_data_i),
    .out_ready_i (out_ready_i),
    .out_valid_o (out_valid_o),
    .out_data_o  (out_data_o),
    .out_sof_o   (out_sof_o),
    .running_o   (running_o)
  );
  rofb_partner u_partner
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .slow_i    (slow),
    .ready_o   (out_ready_i),
    .adc_o     (adc_data_i)
  );
  ////////////////////////////////////////
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  function automatic bit ovh(input int p);
    int o;
    o = p - ((p / 508 > 9) ? 9 : p / 508) * 508;
    return p == 0 || p == 3 || (o >= 6 && o <= 27 && o % 3 == 0);
  endfunction : ovh
  // Every I/Q byte of the last frame taken, from lo up to hi, is zero.
  task automatic iq_zero(input int lo, input int hi);
    for (int p = lo; p < hi; p++)
      if (!ovh(p))
        check(40'(fb[p]), 40'h0);
  endtask : iq_zero
  // Takes one frame, moving the select on late, then decodes its fields.
  task automatic run_frame(input logic [2:0] sel, input logic [2:0] nxt);
    int n;
    int b;
    logic [23:0] tg;
    n = 0;
    while (n < 5082)
    begin
      @(negedge sys_clk_i);
      if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
      begin
        if (n == 0)
          sof0 = out_sof_o;
        fb[n] = out_data_o;
        n++;
        if (n == 4700)
          @(posedge sys_clk_i) input_sel_i <= nxt;
      end
    end
    check(40'(sof0), 40'h1);
    check(40'(fb[0]), 40'hB7);
    check(40'(fb[3]), 40'({1'b0, sel, 4'h0}));
    for (int s = 0; s < 10; s++)
    begin
      b = s * 508;
      pw[s] = {fb[b+6], fb[b+9], fb[b+12], fb[b+15], fb[b+18]};
      tg = {fb[b+21], fb[b+24], fb[b+27]};
      check(40'(tg), 40'(fr * 10 + s));
    end
    fr++;
  endtask : run_frame
  task automatic t_zero();
    run_frame(3'h7, 3'h1);
    for (int s = 0; s < 10; s++)
      check(pw[s], 40'h0);
    iq_zero(0, 5082);
    $display("test zero done");
  endtask : t_zero
  task automatic t_impulse();
    @(posedge sys_clk_i) pps_i <= 1'b1;
    run_frame(3'h1, 3'h2);
    for (int s = 1; s < 10; s++)
      check(pw[s], 40'(2 * 128 * 128));
    // Pair one is the mean over four samples of 128 mixed by 1 and -1.
    check(40'({fb[1], fb[2]}), 40'h0020);
    check(40'({fb[4], fb[5]}), 40'hFFE0);
    iq_zero(6, 4700);
    $display("test impulse done");
  endtask : t_impulse
  task automatic t_squares();
    logic [2:0] sq [0:3];
    sq = '{3'h2, 3'h3, 3'h6, 3'h4};
    @(posedge sys_clk_i) pps_i <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      run_frame(sq[k], sq[k+1]);
      for (int s = 1; s < 9; s++)
        check(pw[s+1] - pw[s], 40'(T * 65536));
      // Square edges fall on pair bounds, so every pair mixes to zero.
      iq_zero(0, 4700);
    end
    $display("test squares done");
  endtask : t_squares
  task automatic t_prn();
    run_frame(3'h4, 3'h5);
    for (int s = 1; s < 9; s++)
      check(pw[s+1] - pw[s], 40'(T));
    @(posedge sys_clk_i) slow <= 1'b1;
    run_frame(3'h5, 3'h0);
    check(40'(pw[9] > pw[1]), 40'h1);
    @(posedge sys_clk_i) slow <= 1'b0;
    $display("test random done");
  endtask : t_prn
  task automatic t_adc();
    run_frame(3'h0, 3'h0);
    for (int s = 1; s < 9; s++)
      check(pw[s+1] - pw[s], 40'(T * 64 * 64));
    check(40'(pw[2] > pw[1]), 40'h1);
    $display("test converter done");
  endtask : t_adc
  ////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 106000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    rst_i = 1'b1;
    pps_i = 1'b0;
    input_sel_i = 3'h7;
    slow = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i) pps_i <= 1'b1;
    @(posedge sys_clk_i) pps_i <= 1'b0;
    t_zero();
    t_impulse();
    t_squares();
    t_prn();
    t_adc();
    tally_and_finish();
  end
endmodule : tb_rofb_frame_builder
